// File: verilog/exec_regs.svh
// Purpose: Offsets, opcodes, field positions and reset values of the executor
// Assumes: Byte offsets of one 32-bit AHB-Lite slave, one word per register
// Notes:   Definitions only
`ifndef EXEC_REGS_SVH
`define EXEC_REGS_SVH
// Register byte offsets (low 12 address bits)
`define OFS_INSTR       12'h000
`define OFS_WREG        12'h004
`define OFS_FSR0        12'h008
`define OFS_FSR1        12'h00C
`define OFS_OPTION      12'h010
`define OFS_INTCTL      12'h014
`define OFS_PWRCTL      12'h018
`define OFS_PC          12'h01C
`define OFS_STACK       12'h020
`define OFS_STATUS      12'h024
`define OFS_LASTOP      12'h028
// File memory window: 0x200 + 4 * file address
`define RAM_SEL         3'h1
// Opcode patterns
`define OP_MASK_DIRECT  14'h3F80
`define OP_DIRECT       14'h0080
`define OP_MASK_IND     14'h3FF8
`define OP_IND          14'h0018
`define OP_MASK_REL     14'h3F80
`define OP_REL          14'h3F80
`define OP_NOP          14'h0000
`define OP_OPTION       14'h0062
`define OP_SWRESET      14'h0001
`define OP_RETINT       14'h0009
// Opcode field positions
`define F_IND_SEL       2
`define F_REL_SEL       6
`define F_MODE_MSB      1
`define F_K_MSB         5
`define F_FILE_MSB      6
// Virtual indirect file addresses
`define IND0_ADDR       7'h00
`define IND1_ADDR       7'h01
// Bits in control registers
`define IRQ_EN_BIT      7
`define RSTI_FLAG_BIT   2
// Reset values and steps
`define WREG_RST        8'h00
`define FSR_RST         16'h0000
`define OPTION_RST      8'hFF
`define INTCTL_RST      8'h00
`define PWRCTL_RST      8'h04
`define STATUS_RST      8'h00
`define PC_RST          15'h0000
`define PTR_STEP        16'h0001
`define PC_STEP         15'h0001
`endif

// File: verilog/exec_pkg.sv
// Purpose: Types shared by the store/return executor
// Assumes: Nothing beyond the register header
// Notes:   Encodings of the pointer modes follow the opcode mode field
package exec_pkg;
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_RD_WAIT = 2'b01,
    ST_EXEC2   = 2'b10
  } bus_state_t;
  typedef enum logic [1:0] {
    MODE_PREINC  = 2'b00,
    MODE_PREDEC  = 2'b01,
    MODE_POSTINC = 2'b10,
    MODE_POSTDEC = 2'b11
  } ptr_mode_t;
endpackage : exec_pkg

// File: verilog/file_ram.sv
// Purpose: Data file memory with one write port and a registered read port
// Assumes: Write and read addresses are valid every cycle
// Notes:   Contents are not reset, as in a real SRAM
`timescale 1ns/1ps
`default_nettype none
module file_ram #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  // Clock
  input  wire logic          clk,
  // Write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  // Read port
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata_r
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_r <= mem[raddr];
  end
endmodule : file_ram
`default_nettype wire

// File: verilog/return_stack.sv
// Purpose: Circular hardware return stack
// Assumes: Push and pop are never asked in the same cycle
// Notes:   Overflow and underflow wrap silently, old entries are overwritten
`timescale 1ns/1ps
`default_nettype none
module return_stack #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 15
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             clr,
  // Stack operations
  input  wire logic             push,
  input  wire logic             pop,
  input  wire logic [WIDTH-1:0] push_data,
  output logic      [WIDTH-1:0] stack_top
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [PW-1:0]    ptr_r;
  logic [PW-1:0]    top_idx;

  assign top_idx = ptr_r - {{(PW-1){1'b0}}, 1'b1};
  assign stack_top = mem[top_idx];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_r <= '0;
    end else if (clr) begin
      ptr_r <= '0;
    end else if (push) begin
      ptr_r <= ptr_r + {{(PW-1){1'b0}}, 1'b1};
    end else if (pop) begin
      ptr_r <= top_idx;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[ptr_r] <= push_data;
    end
  end
endmodule : return_stack
`default_nettype wire

// File: verilog/store_return_exec.sv
// Purpose: Executes the store, no-operation, software reset and return
//          instructions of an 8-bit core, fed one opcode at a time over AHB-Lite
// Assumes: Single word transfers; HSIZE is not checked
// Notes:   Instruction clock is CLOCK; a write to the instruction register
//          executes the opcode in its data phase
//
// Notes on behaviour
// - Direct store copies working register to file address 0..127, one cycle.
// - Indirect mode field: 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec.
// - Indirect address is pointer+1, pointer-1, the pointer itself (post forms) or pointer plus signed offset.
// - Pointer ends incremented, decremented, or unchanged for relative offset.
// - One operand bit picks which of two pointers the indirect store uses.
// - Virtual indirect registers redirect to the address held in their pointer.
// - Pointers are 16 bits and wrap modulo 65536.
// - Indirect stores and pointer steps leave all status flags alone.
// - Option load copies working register to option register in one cycle.
// - Software reset resets the device and clears the reset-instruction flag.
// - Return from interrupt pops stack into program counter, two cycles.
// - Return from interrupt also sets interrupt enable, bit 7.
`timescale 1ns/1ps
`default_nettype none
`include "exec_regs.svh"
module store_return_exec
  import exec_pkg::*;
#(
  parameter int FILE_AW     = 7,
  parameter int STACK_DEPTH = 16,
  parameter int PC_W        = 15
) (
  // Clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RESETN,
  // AHB-Lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // Core side
  output logic      [7:0]  OPTION_VALUE,
  output logic             IRQ_ENABLE,
  output logic             SW_RESET_PULSE
);
  // ****************************************************
  // Arithmetic helpers
  // ****************************************************
  function automatic logic [15:0] ptr_step(input logic [15:0] p,
                                           input logic [1:0]  mode);
    // Native 16-bit arithmetic gives the wrap for free
    ptr_step = mode[0] ? p - `PTR_STEP : p + `PTR_STEP;
  endfunction : ptr_step

  function automatic logic [15:0] sext_k(input logic [5:0] k);
    sext_k = {{10{k[`F_K_MSB]}}, k};
  endfunction : sext_k

  // ****************************************************
  // State
  // ****************************************************
  bus_state_t           state_r;
  logic                 dp_valid_r;
  logic                 dp_write_r;
  logic [11:0]          dp_addr_r;
  logic [31:0]          hrdata_r;
  logic                 hready_r;
  logic                 hresp_r;
  logic [7:0]           w_r;
  logic [15:0]          fsr0_r;
  logic [15:0]          fsr1_r;
  logic [7:0]           option_r;
  logic [7:0]           intctl_r;
  logic [7:0]           pwrctl_r;
  logic [7:0]           status_r;
  logic [PC_W-1:0]      pc_r;
  logic [13:0]          last_op_r;
  logic                 sw_reset_r;
  logic [31:0]          reg_rdata;
  logic [FILE_AW-1:0]   ram_waddr;
  logic [7:0]           ram_wdata;
  logic [7:0]           ram_q;
  logic [PC_W-1:0]      stack_top;

  // ****************************************************
  // Bus decode
  // ****************************************************
  wire        addr_take  = HSEL && HREADY && HTRANS[1];
  wire        take_ram   = HADDR[11:9] == `RAM_SEL;
  wire        wr         = dp_valid_r && dp_write_r;
  wire        dp_ram     = dp_addr_r[11:9] == `RAM_SEL;
  wire        bus_ram_wr = wr && dp_ram;
  wire        wr_instr   = wr && (dp_addr_r == `OFS_INSTR);
  wire        wr_wreg    = wr && (dp_addr_r == `OFS_WREG);
  wire        wr_fsr0    = wr && (dp_addr_r == `OFS_FSR0);
  wire        wr_fsr1    = wr && (dp_addr_r == `OFS_FSR1);
  wire        wr_intctl  = wr && (dp_addr_r == `OFS_INTCTL);
  wire        wr_pwrctl  = wr && (dp_addr_r == `OFS_PWRCTL);
  wire        wr_pc      = wr && (dp_addr_r == `OFS_PC);
  wire        wr_stack   = wr && (dp_addr_r == `OFS_STACK);
  wire        wr_status  = wr && (dp_addr_r == `OFS_STATUS);

  // ****************************************************
  // Instruction decode
  // ****************************************************
  wire [13:0] op         = HWDATA[13:0];
  wire        is_direct  = wr_instr && ((op & `OP_MASK_DIRECT) == `OP_DIRECT);
  wire        is_ind     = wr_instr && ((op & `OP_MASK_IND) == `OP_IND);
  wire        is_rel     = wr_instr && ((op & `OP_MASK_REL) == `OP_REL);
  wire        is_nop     = wr_instr && (op == `OP_NOP);
  wire        is_option  = wr_instr && (op == `OP_OPTION);
  wire        is_swreset = wr_instr && (op == `OP_SWRESET);
  wire        is_retint  = wr_instr && (op == `OP_RETINT);
  wire        is_store   = is_direct || is_ind || is_rel;
  wire        one_cycle  = is_store || is_nop || is_option;
  wire [1:0]  upd_mode   = op[`F_MODE_MSB:0];
  wire [5:0]  k          = op[`F_K_MSB:0];
  wire [6:0]  f          = op[`F_FILE_MSB:0];
  wire        sel_n      = is_rel ? op[`F_REL_SEL] : op[`F_IND_SEL];

  // ****************************************************
  // Indirect addressing
  // ****************************************************
  // Pointer choice by the operand bit
  wire [15:0] ptr_sel    = sel_n ? fsr1_r : fsr0_r;
  wire [15:0] ptr_moved  = ptr_step(ptr_sel, upd_mode);
  // Pre forms use the moved pointer, post forms the old one
  wire [15:0] ea_mode    = upd_mode[1] ? ptr_sel : ptr_moved;
  wire [15:0] ind_ea     = is_rel ? ptr_sel + sext_k(k) : ea_mode;
  wire [15:0] ptr_after  = is_rel ? ptr_sel : ptr_moved;
  wire        upd_fsr0   = (is_ind || is_rel) && !sel_n;
  wire        upd_fsr1   = (is_ind || is_rel) && sel_n;
  // Virtual indirect addresses hold no storage; they follow the pointer
  wire [6:0]  dir_ea     = (f == `IND0_ADDR) ? fsr0_r[6:0] :
                           (f == `IND1_ADDR) ? fsr1_r[6:0] : f;
  // Only the low bits of a 16-bit address reach the small file memory
  wire [15:0] store_ea   = is_direct ? {9'h000, dir_ea} : ind_ea;

  assign ram_waddr = is_store ? store_ea[FILE_AW-1:0]
                              : dp_addr_r[FILE_AW+1:2];
  assign ram_wdata = is_store ? w_r : HWDATA[7:0];

  // ****************************************************
  // Register read mux
  // ****************************************************
  always_comb begin
    reg_rdata = 32'h0000_0000;
    if (HADDR[11:0] == `OFS_WREG) begin
      reg_rdata[7:0] = w_r;
    end else if (HADDR[11:0] == `OFS_FSR0) begin
      reg_rdata[15:0] = fsr0_r;
    end else if (HADDR[11:0] == `OFS_FSR1) begin
      reg_rdata[15:0] = fsr1_r;
    end else if (HADDR[11:0] == `OFS_OPTION) begin
      reg_rdata[7:0] = option_r;
    end else if (HADDR[11:0] == `OFS_INTCTL) begin
      reg_rdata[7:0] = intctl_r;
    end else if (HADDR[11:0] == `OFS_PWRCTL) begin
      reg_rdata[7:0] = pwrctl_r;
    end else if (HADDR[11:0] == `OFS_PC) begin
      reg_rdata[PC_W-1:0] = pc_r;
    end else if (HADDR[11:0] == `OFS_STACK) begin
      reg_rdata[PC_W-1:0] = stack_top;
    end else if (HADDR[11:0] == `OFS_STATUS) begin
      reg_rdata[7:0] = status_r;
    end else if (HADDR[11:0] == `OFS_LASTOP) begin
      reg_rdata[13:0] = last_op_r;
    end
  end

  // ****************************************************
  // Bus state machine
  // ****************************************************
  // Return from interrupt holds the bus for its second cycle
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      state_r  <= ST_IDLE;
      hready_r <= 1'b1;
      hresp_r  <= 1'b0;
      hrdata_r <= 32'h0000_0000;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (is_retint) begin
            state_r  <= ST_EXEC2;
            hready_r <= 1'b0;
          end else if (addr_take && !HWRITE && take_ram) begin
            state_r  <= ST_RD_WAIT;
            hready_r <= 1'b0;
          end else if (addr_take && !HWRITE) begin
            hrdata_r <= reg_rdata;
          end
        end
        ST_RD_WAIT: begin
          hrdata_r <= {24'h00_0000, ram_q};
          hready_r <= 1'b1;
          state_r  <= ST_IDLE;
        end
        ST_EXEC2: begin
          hready_r <= 1'b1;
          state_r  <= ST_IDLE;
        end
        default: begin
          hready_r <= 1'b1;
          state_r  <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      dp_valid_r <= 1'b0;
      dp_write_r <= 1'b0;
      dp_addr_r  <= 12'h000;
    end else begin
      dp_valid_r <= addr_take;
      if (addr_take) begin
        dp_write_r <= HWRITE;
        dp_addr_r  <= HADDR[11:0];
      end
    end
  end

  // ****************************************************
  // Core registers
  // ****************************************************
  // Software reset is a synchronous clear of everything it owns
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      w_r      <= `WREG_RST;
      option_r <= `OPTION_RST;
      status_r <= `STATUS_RST;
    end else if (is_swreset) begin
      w_r      <= `WREG_RST;
      option_r <= `OPTION_RST;
      status_r <= `STATUS_RST;
    end else begin
      if (wr_wreg) begin
        w_r <= HWDATA[7:0];
      end
      if (is_option) begin
        option_r <= w_r;
      end
      // Only software writes flags; no store path touches them
      if (wr_status) begin
        status_r <= HWDATA[7:0];
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      fsr0_r <= `FSR_RST;
      fsr1_r <= `FSR_RST;
    end else if (is_swreset) begin
      fsr0_r <= `FSR_RST;
      fsr1_r <= `FSR_RST;
    end else begin
      if (upd_fsr0) begin
        fsr0_r <= ptr_after;
      end else if (wr_fsr0) begin
        fsr0_r <= HWDATA[15:0];
      end
      if (upd_fsr1) begin
        fsr1_r <= ptr_after;
      end else if (wr_fsr1) begin
        fsr1_r <= HWDATA[15:0];
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      pc_r <= `PC_RST;
    end else if (is_swreset) begin
      pc_r <= `PC_RST;
    end else if (is_retint) begin
      pc_r <= stack_top;
    end else if (one_cycle) begin
      pc_r <= pc_r + `PC_STEP;
    end else if (wr_pc) begin
      pc_r <= HWDATA[PC_W-1:0];
    end
  end

  // Software reset clears the reset-instruction flag and keeps the other power-control bits
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      intctl_r   <= `INTCTL_RST;
      pwrctl_r   <= `PWRCTL_RST;
      sw_reset_r <= 1'b0;
      last_op_r  <= 14'h0000;
    end else begin
      sw_reset_r <= is_swreset;
      if (wr_instr) begin
        last_op_r <= op;
      end
      if (is_swreset) begin
        intctl_r <= `INTCTL_RST;
        pwrctl_r[`RSTI_FLAG_BIT] <= 1'b0;
      end else if (is_retint) begin
        intctl_r[`IRQ_EN_BIT] <= 1'b1;
      end else if (wr_intctl) begin
        intctl_r <= HWDATA[7:0];
      end else if (wr_pwrctl) begin
        pwrctl_r <= HWDATA[7:0];
      end
    end
  end

  // ****************************************************
  // Memories
  // ****************************************************
  file_ram #(
    .AW (FILE_AW),
    .DW (8)
  ) u_file_ram (
    .clk     (CLOCK),
    .we      (is_store || bus_ram_wr),
    .waddr   (ram_waddr),
    .wdata   (ram_wdata),
    .raddr   (HADDR[FILE_AW+1:2]),
    .rdata_r (ram_q)
  );

  return_stack #(
    .DEPTH (STACK_DEPTH),
    .WIDTH (PC_W)
  ) u_return_stack (
    .clk       (CLOCK),
    .rst_n     (RESETN),
    .clr       (is_swreset),
    .push      (wr_stack),
    .pop       (is_retint),
    .push_data (HWDATA[PC_W-1:0]),
    .stack_top (stack_top)
  );

  assign HRDATA         = hrdata_r;
  assign HREADYOUT      = hready_r;
  assign HRESP          = hresp_r;
  assign OPTION_VALUE   = option_r;
  assign IRQ_ENABLE     = intctl_r[`IRQ_EN_BIT];
  assign SW_RESET_PULSE = sw_reset_r;

  // ****************************************************
  // Checks
  // ****************************************************
  chk_direct_store: assert property (@(posedge CLOCK) disable iff (!RESETN)
    is_direct && f > `IND1_ADDR |-> ram_waddr == f && ram_wdata == w_r
      ##1 pc_r == $past(pc_r) + `PC_STEP && HREADYOUT)
    else $error("direct store wrong address, data or length");

  chk_mode_step: assert property (@(posedge CLOCK) disable iff (!RESETN)
    is_ind && !sel_n |-> ram_waddr == 7'(upd_mode[1] ? fsr0_r
      : (upd_mode[0] ? fsr0_r - `PTR_STEP : fsr0_r + `PTR_STEP))
      ##1 fsr0_r == ($past(upd_mode[0]) ? $past(fsr0_r) - `PTR_STEP
                                        : $past(fsr0_r) + `PTR_STEP))
    else $error("indirect mode field decoded wrongly");

  chk_rel_addr: assert property (@(posedge CLOCK) disable iff (!RESETN)
    is_rel |-> ram_waddr == 7'(16'($signed(ptr_sel) + $signed(k))) && ram_wdata == w_r)
    else $error("relative store address wrong");

  chk_rel_keeps: assert property (@(posedge CLOCK) disable iff (!RESETN)
    is_rel |=> $stable(fsr0_r) && $stable(fsr1_r))
    else $error("relative store moved a pointer");

  chk_indirect_redirect: assert property (@(posedge CLOCK) disable iff (!RESETN)
    is_direct && f == `IND1_ADDR |-> ram_waddr == fsr1_r[6:0])
    else $error("virtual register not redirected");

  chk_ptr_wrap: assert property (@(posedge CLOCK) disable iff (!RESETN)
    is_ind && !sel_n && upd_mode == MODE_PREDEC && fsr0_r == 16'h0000
      |=> fsr0_r == 16'hFFFF)
    else $error("pointer did not wrap below zero");

  chk_flags_kept: assert property (@(posedge CLOCK) disable iff (!RESETN)
    is_store |=> $stable(status_r))
    else $error("store changed status flags");

  chk_option_load: assert property (@(posedge CLOCK) disable iff (!RESETN)
    is_option |=> OPTION_VALUE == $past(w_r) && HREADYOUT)
    else $error("option load wrong");

  chk_reset_flag: assert property (@(posedge CLOCK) disable iff (!RESETN)
    is_swreset |=> SW_RESET_PULSE && !pwrctl_r[`RSTI_FLAG_BIT] && pc_r == `PC_RST
      ##1 !SW_RESET_PULSE)
    else $error("software reset wrong");

  chk_return_pc: assert property (@(posedge CLOCK) disable iff (!RESETN)
    is_retint |=> pc_r == $past(stack_top) && !HREADYOUT ##1 HREADYOUT)
    else $error("return did not load pc in two cycles");

  chk_irq_enable: assert property (@(posedge CLOCK) disable iff (!RESETN)
    is_retint |=> IRQ_ENABLE [*2])
    else $error("return did not set interrupt enable");

  chk_nop_only_pc: assert property (@(posedge CLOCK) disable iff (!RESETN)
    is_nop |=> pc_r == $past(pc_r) + `PC_STEP && $stable(w_r) && $stable(fsr0_r)
      && $stable(fsr1_r) && $stable(option_r) && $stable(status_r))
    else $error("no-operation changed state");
endmodule : store_return_exec
`default_nettype wire

// File: verif/ahb_master.sv
// Purpose: AHB-Lite master that issues single word transfers to the executor
// Assumes: One slave, its HREADYOUT is the bus ready
// Notes:   Raises hang when a wait runs past its bound
`timescale 1ns/1ps
`default_nettype none
module ahb_master (
  // Clock
  input  wire logic        clk,
  // Bus
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata,
  // Status
  output logic             hang
);
  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0000_0000;
    hang   = 1'b0;
  end
  // Leaves one idle cycle between transfers, so no address phase meets a write data phase
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    int n;
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {20'h00000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 64);
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= wd;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 128);
    rd = hrdata;
    if (n >= 64) hang <= 1'b1;
  endtask : xfer
endmodule : ahb_master
`default_nettype wire

// File: verif/cpu_move_return_instr_exec_test.sv
// Purpose: Self-checking bench of the store, no-op, reset and return executor
// Assumes: Opcodes fed one at a time through the instruction register
// Notes:   Random operands from a fixed xorshift seed, corners mixed in
`timescale 1ns/1ps
`default_nettype none
`include "exec_regs.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module cpu_move_return_instr_exec_test;
  logic        CLOCK;
  logic        RESETN;
  logic        HSEL, HWRITE, HREADYOUT, HRESP, IRQ_ENABLE, SW_RESET_PULSE, bus_hang;
  logic [31:0] HADDR, HWDATA, HRDATA, r, q, seed;
  logic [1:0]  HTRANS;
  logic [2:0]  HSIZE;
  logic [7:0]  OPTION_VALUE, w, s;
  logic [15:0] p;
  logic [5:0]  k;
  logic [6:0]  f;
  int          err_total, cmp_count;
  store_return_exec i_dut (.CLOCK(CLOCK), .RESETN(RESETN), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .OPTION_VALUE(OPTION_VALUE),
    .IRQ_ENABLE(IRQ_ENABLE), .SW_RESET_PULSE(SW_RESET_PULSE));
  ahb_master i_master (.clk(CLOCK), .hready(HREADYOUT), .hrdata(HRDATA), .hsel(HSEL),
    .haddr(HADDR), .htrans(HTRANS), .hwrite(HWRITE), .hsize(HSIZE), .hwdata(HWDATA),
    .hang(bus_hang));
  // ******************************
  // Helpers and expectations
  // ******************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  // Pre modes store at the moved pointer, post modes at the old one
  function automatic logic [15:0] eff(logic [15:0] q, logic [1:0] m);
    return m[1] ? q : (m[0] ? q - 16'h0001 : q + 16'h0001);
  endfunction : eff
  function automatic logic [15:0] moved(logic [15:0] q, logic [1:0] m);
    return m[0] ? q - 16'h0001 : q + 16'h0001;
  endfunction : moved
  function automatic logic [11:0] fa(logic [6:0] a);
    return 12'h200 + {3'b000, a, 2'b00};
  endfunction : fa
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    i_master.xfer(1'b1, a, d, x);
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    i_master.xfer(1'b0, a, 32'h0000_0000, d);
  endtask : rd
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  initial begin
    CLOCK = 1'b0;
    forever #12.5 CLOCK = ~CLOCK;
  end
  always @(posedge bus_hang) begin
    err_total++;
    give_verdict();
  end
  // ******************************
  // Main sequence
  // ******************************
  initial begin
    err_total = 0;
    cmp_count = 0;
    seed = 32'h7FB3C7D5;
    RESETN = 1'b0;
    repeat (12) @(posedge CLOCK);
    RESETN <= 1'b1;
    #1;
    `CHK(OPTION_VALUE, 8'hFF)
    `CHK(IRQ_ENABLE, 1'b0)
    rd(`OFS_PWRCTL, r);
    `CHK(r, 32'h0000_0004)
    rd(12'h100, r);
    `CHK(r, 32'h0000_0000)
    for (int i = 0; i < 4; i++) begin
      w = rnd();
      f = (i == 3) ? 7'h7F : 7'd2 + 7'(rnd() % 126);
      wr(`OFS_WREG, {24'h0, w});
      wr(`OFS_INSTR, {18'h0, `OP_DIRECT | 14'(f)});
      rd(fa(f), r);
      `CHK(r, {24'h0, w})
    end
    for (int i = 0; i < 8; i++) begin
      p = (i == 0) ? 16'hFFFF : (i == 2) ? 16'h0000 : 16'(rnd());
      w = rnd();
      s = rnd();
      wr(`OFS_FSR0 + 12'(4 * i[0]), {16'h0, p});
      wr(`OFS_WREG, {24'h0, w});
      wr(`OFS_STATUS, {24'h0, s});
      wr(`OFS_INSTR, {18'h0, `OP_IND | 14'(i[0] << 2) | 14'(i[2:1])});
      rd(`OFS_FSR0 + 12'(4 * i[0]), r);
      `CHK(r, {16'h0, moved(p, i[2:1])})
      rd(fa(eff(p, i[2:1])), r);
      `CHK(r, {24'h0, w})
      rd(`OFS_STATUS, r);
      `CHK(r, {24'h0, s})
    end
    for (int i = 0; i < 4; i++) begin
      p = 16'(rnd());
      w = rnd();
      k = (i == 0) ? 6'h20 : (i == 1) ? 6'h1F : 6'(rnd());
      wr(`OFS_FSR0 + 12'(4 * i[0]), {16'h0, p});
      wr(`OFS_WREG, {24'h0, w});
      wr(`OFS_INSTR, {18'h0, `OP_REL | 14'(i[0] << 6) | 14'(k)});
      rd(fa(7'(p + {{10{k[5]}}, k})), r);
      `CHK(r, {24'h0, w})
      rd(`OFS_FSR0 + 12'(4 * i[0]), r);
      `CHK(r, {16'h0, p})
    end
    f = 7'd2 + 7'(rnd() % 126);
    w = rnd();
    wr(`OFS_FSR1, {25'h0, f});
    wr(`OFS_WREG, {24'h0, w});
    wr(`OFS_INSTR, {18'h0, `OP_DIRECT | 14'(`IND1_ADDR)});
    rd(fa(f), r);
    `CHK(r, {24'h0, w})
    rd(`OFS_PC, p);
    wr(`OFS_INSTR, {18'h0, `OP_NOP});
    rd(`OFS_PC, r);
    `CHK(r[14:0], p[14:0] + 15'h0001)
    r = {17'h0, 15'(rnd())};
    wr(`OFS_STACK, r);
    wr(`OFS_INTCTL, 32'h0000_0000);
    wr(`OFS_INSTR, {18'h0, `OP_RETINT});
    #1;
    `CHK(HREADYOUT, 1'b0)
    rd(`OFS_PC, q);
    `CHK(q, r)
    `CHK(IRQ_ENABLE, 1'b1)
    w = 8'(rnd()) & 8'hFE;
    wr(`OFS_WREG, {24'h0, w});
    wr(`OFS_INSTR, {18'h0, `OP_OPTION});
    #1;
    `CHK(OPTION_VALUE, w)
    wr(`OFS_PWRCTL, 32'h0000_00FF);
    wr(`OFS_INSTR, {18'h0, `OP_SWRESET});
    s[0] = 1'b0;
    repeat (3) begin
      #1 s[0] = s[0] | (SW_RESET_PULSE === 1'b1);
      @(posedge CLOCK);
    end
    `CHK(s[0], 1'b1)
    rd(`OFS_PWRCTL, r);
    `CHK(r, 32'h0000_00FB)
    rd(`OFS_WREG, r);
    `CHK(r, 32'h0000_0000)
    `CHK(OPTION_VALUE, 8'hFF)
    `CHK(IRQ_ENABLE, 1'b0)
    `CHK(HRESP, 1'b0)
    give_verdict();
  end
endmodule : cpu_move_return_instr_exec_test
`default_nettype wire
